// File: hdl/mcio_pkg.sv
package mcio_pkg;
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
    localparam int unsigned PANEL_SETTLE_MS = 70;
    localparam int unsigned PANEL_SETTLE_CYC = PANEL_SETTLE_MS * CYC_PER_MS;
    localparam int unsigned SELF_CAL_MS     = 55;
    localparam int unsigned SELF_CAL_CYC    = SELF_CAL_MS * CYC_PER_MS;
    localparam logic [6:0]  PANEL_ZERO      = 7'h00;
    localparam logic [6:0]  PANEL_ONES      = 7'h7F;
    localparam logic [31:0] CNT_ZERO        = 32'h0000_0000;

    // Register word offsets
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_JUDGE  = 4'h1;
    localparam logic [3:0] OFS_STATUS = 4'h2;
    localparam logic [3:0] OFS_EVENT  = 4'h3;
    // CTRL fields
    localparam int CTRL_EXT_TRIG  = 0;
    localparam int CTRL_CAL_MAN   = 1;
    localparam int CTRL_RATE_LO   = 2;
    localparam int CTRL_CMP_MAN   = 4;
    localparam int CTRL_MODE_LO   = 5;
    localparam int CTRL_ERR_SYNC  = 7;
    localparam int CTRL_EOM_PULSE = 8;
    localparam int CTRL_PW_LO     = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0001_0000;
    // STATUS fields
    localparam int ST_MEAS_REQ  = 0;
    localparam int ST_ACCUM     = 1;
    localparam int ST_ZERO      = 2;
    localparam int ST_PRINT     = 3;
    localparam int ST_LOAD      = 4;
    localparam int ST_PANEL_LO  = 8;

    typedef enum logic [1:0] {
        RATE_FASTEST = 2'b00,
        RATE_FAST    = 2'b01,
        RATE_MEDIUM  = 2'b10,
        RATE_SLOW    = 2'b11
    } mcio_rate_t;

    typedef enum logic [1:0] {
        QTY_DUAL = 2'b00,
        QTY_RES  = 2'b01,
        QTY_VOLT = 2'b10
    } mcio_qty_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETTLE = 3'b001,
        ST_MEAS   = 3'b010,
        ST_CALC   = 3'b011,
        ST_CAL    = 3'b100
    } mcio_state_t;
endpackage

// File: hdl/mcio_port.sv
`timescale 1ns/1ns
module mcio_port #(
    parameter int unsigned SETTLE_CYC = mcio_pkg::PANEL_SETTLE_CYC,
    parameter int unsigned CAL_CYC    = mcio_pkg::SELF_CAL_CYC,
    parameter int unsigned MS_CYC     = mcio_pkg::CYC_PER_MS
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Controller inputs, active low
    input  wire logic        trig_n,
    input  wire logic [6:0]  panel_sel_n,
    input  wire logic        cal_req_n,
    input  wire logic        zero_req_n,
    input  wire logic        print_req_n,
    input  wire logic        judge_gate_n,
    // Measurement core side
    input  wire logic        meas_end,
    input  wire logic        meas_fault,
    input  wire logic        probe_fault,
    input  wire logic [2:0]  res_judge,
    input  wire logic [2:0]  volt_judge,
    output logic             meas_start,
    output logic             panel_load,
    output logic [6:0]       panel_num,
    output logic             cal_start,
    output logic             zero_start,
    output logic             print_start,
    output logic             accum_start,
    output logic             judge_en,
    // Controller outputs, active low
    output logic             meas_done_n,
    output logic             index_n,
    output logic             fault_n,
    output logic             res_above_n,
    output logic             res_within_n,
    output logic             res_below_n,
    output logic             volt_above_n,
    output logic             volt_within_n,
    output logic             volt_below_n,
    output logic             pass_n,
    output logic             fail_n
);
    // ****************************************
    // State
    // ****************************************
    localparam int NIN = 12;

    typedef struct packed {
        logic [NIN-1:0]       s1;
        logic [NIN-1:0]       s2;
        logic [NIN-1:0]       s3;
        logic [NIN-1:0]       lvl;
        logic [31:0]          ctrl;
        logic [6:0]           lastPanel;
        logic [31:0]          cnt;
        logic [31:0]          pulseCnt;
        mcio_pkg::mcio_state_t st;
        logic                 doneN;
        logic                 faultSyncN;
        logic [5:0]           judgeN;
        logic [5:0]           events;
        logic                 ack;
        logic [31:0]          rdata;
        logic                 measStart;
        logic                 panelLoad;
        logic                 calStart;
        logic                 zeroStart;
        logic                 printStart;
        logic                 accumStart;
        logic                 armed;
    } mcio_state_s_t;

    mcio_state_s_t q_reg;
    mcio_state_s_t q_next;

    logic [NIN-1:0] rawIn;
    logic [NIN-1:0] agree;
    logic [NIN-1:0] fall;
    logic [6:0]     panelNow;
    logic           extTrig;
    logic           calMan;
    mcio_pkg::mcio_rate_t rate;
    mcio_pkg::mcio_qty_t  qty;
    logic           cmpMan;
    logic           errSync;
    logic           eomPulse;
    logic [15:0]    pulseMs;
    logic           bothIn;
    logic           passN;
    logic           trigFall;
    logic           strobeMeas;
    logic           busSel;

    assign rawIn = {judge_gate_n, print_req_n, zero_req_n, cal_req_n,
                    panel_sel_n, trig_n};

    // ****************************************
    // Synchroniser edge detect
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_in
            // Change accepted once stages two and three agree
            assign agree[gi] = (q_reg.s2[gi] == q_reg.s3[gi]);
            assign fall[gi]  = agree[gi] && q_reg.lvl[gi]
                               && !q_reg.s2[gi];
        end
    endgenerate

    assign extTrig  = q_reg.ctrl[mcio_pkg::CTRL_EXT_TRIG];
    assign calMan   = q_reg.ctrl[mcio_pkg::CTRL_CAL_MAN];
    assign rate     = mcio_pkg::mcio_rate_t'(
                      q_reg.ctrl[mcio_pkg::CTRL_RATE_LO +: 2]);
    assign cmpMan   = q_reg.ctrl[mcio_pkg::CTRL_CMP_MAN];
    assign qty      = mcio_pkg::mcio_qty_t'(
                      q_reg.ctrl[mcio_pkg::CTRL_MODE_LO +: 2]);
    assign errSync  = q_reg.ctrl[mcio_pkg::CTRL_ERR_SYNC];
    assign eomPulse = q_reg.ctrl[mcio_pkg::CTRL_EOM_PULSE];
    assign pulseMs  = q_reg.ctrl[mcio_pkg::CTRL_PW_LO +: 16];
    // Panel number is active low on the pins
    assign panelNow = ~q_reg.lvl[7:1];
    assign trigFall = fall[0];
    assign busSel   = avs_read || avs_write;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        q_next = q_reg;
        q_next.s1 = rawIn;
        q_next.s2 = q_reg.s1;
        q_next.s3 = q_reg.s2;
        for (int i = 0; i < NIN; i++) begin
            if (agree[i]) begin
                q_next.lvl[i] = q_reg.s2[i];
            end
        end
        q_next.measStart  = 1'b0;
        q_next.panelLoad  = 1'b0;
        q_next.calStart   = 1'b0;
        q_next.zeroStart  = 1'b0;
        q_next.printStart = 1'b0;
        q_next.accumStart = 1'b0;
        q_next.ack        = 1'b0;
        strobeMeas        = 1'b0;

        if (trigFall) begin
            q_next.accumStart = 1'b1;
            if (extTrig && q_reg.st == mcio_pkg::ST_IDLE) begin
                q_next.lastPanel = panelNow;
                if (panelNow != q_reg.lastPanel
                    && panelNow != mcio_pkg::PANEL_ZERO
                    && panelNow != mcio_pkg::PANEL_ONES) begin
                    q_next.panelLoad = 1'b1;
                    q_next.cnt       = mcio_pkg::CNT_ZERO;
                    q_next.st        = mcio_pkg::ST_SETTLE;
                end else begin
                    strobeMeas = 1'b1;
                end
            end
            // Hold mode releases done at the next strobe
            q_next.doneN = 1'b1;
        end
        if (fall[9]) begin
            q_next.zeroStart = 1'b1;
        end
        if (fall[10]) begin
            q_next.printStart = 1'b1;
        end

        case (q_reg.st)
            mcio_pkg::ST_IDLE: begin
                if (strobeMeas) begin
                    q_next.measStart = 1'b1;
                    q_next.st        = mcio_pkg::ST_MEAS;
                end else if (fall[8] && calMan
                             && rate != mcio_pkg::RATE_SLOW) begin
                    q_next.calStart = 1'b1;
                    q_next.cnt      = mcio_pkg::CNT_ZERO;
                    q_next.st       = mcio_pkg::ST_CAL;
                end
            end
            mcio_pkg::ST_SETTLE: begin
                q_next.cnt = q_reg.cnt + 32'h1;
                if (q_reg.cnt >= 32'(SETTLE_CYC - 1)) begin
                    q_next.measStart = 1'b1;
                    q_next.st        = mcio_pkg::ST_MEAS;
                end
            end
            mcio_pkg::ST_MEAS: begin
                if (meas_end) begin
                    q_next.st = mcio_pkg::ST_CALC;
                end
            end
            mcio_pkg::ST_CALC: begin
                q_next.doneN      = 1'b0;
                q_next.faultSyncN = ~meas_fault;
                if (!cmpMan || !q_reg.lvl[11]) begin
                    q_next.judgeN = ~{volt_judge, res_judge};
                end
                q_next.pulseCnt = mcio_pkg::CNT_ZERO;
                q_next.st       = mcio_pkg::ST_IDLE;
            end
            mcio_pkg::ST_CAL: begin
                q_next.cnt = q_reg.cnt + 32'h1;
                if (q_reg.cnt >= 32'(CAL_CYC - 1)) begin
                    q_next.st = mcio_pkg::ST_IDLE;
                end
            end
            default: begin
                q_next.st = mcio_pkg::ST_IDLE;
            end
        endcase

        q_next.armed = q_reg.armed | (q_next.st != mcio_pkg::ST_IDLE);

        // Pulse mode: done ends after set width in ms
        if (eomPulse && !q_reg.doneN) begin
            q_next.pulseCnt = q_reg.pulseCnt + 32'h1;
            if (q_reg.pulseCnt >= 32'(pulseMs) * 32'(MS_CYC) - 32'h1) begin
                q_next.doneN = 1'b1;
            end
        end

        q_next.events = {q_reg.events[5] | (q_reg.st == mcio_pkg::ST_CALC),
                         q_reg.events[4] | q_reg.panelLoad,
                         q_reg.events[3] | q_reg.printStart,
                         q_reg.events[2] | q_reg.zeroStart,
                         q_reg.events[1] | q_reg.accumStart,
                         q_reg.events[0] | q_reg.measStart};

        // Single-cycle wait, answer on the next edge
        if (busSel) begin
            q_next.ack   = !q_reg.ack;
            q_next.rdata = 32'h0000_0000;
            case (avs_address)
                mcio_pkg::OFS_CTRL: begin
                    q_next.rdata = q_reg.ctrl;
                    if (avs_write && q_reg.ack) begin
                        for (int b = 0; b < 4; b++) begin
                            if (avs_byteenable[b]) begin
                                q_next.ctrl[b*8 +: 8] = avs_writedata[b*8 +: 8];
                            end
                        end
                    end
                end
                mcio_pkg::OFS_JUDGE: begin
                    q_next.rdata = {24'h000000, ~pass_n, ~fault_n,
                                    ~q_reg.judgeN};
                end
                mcio_pkg::OFS_STATUS: begin
                    q_next.rdata = {17'h00000, panelNow, 5'h00,
                                    q_reg.st};
                    q_next.rdata[mcio_pkg::ST_PANEL_LO +: 7] = q_reg.lastPanel;
                end
                mcio_pkg::OFS_EVENT: begin
                    q_next.rdata = {26'h0000000, q_reg.events};
                    if (avs_write && q_reg.ack) begin
                        // Set wins over clear: new events ORed back in
                        q_next.events = q_next.events
                                      & ~avs_writedata[5:0]
                                      | {q_reg.st == mcio_pkg::ST_CALC,
                                         q_reg.panelLoad, q_reg.printStart,
                                         q_reg.zeroStart, q_reg.accumStart,
                                         q_reg.measStart};
                    end
                end
                default: begin
                    q_next.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            q_reg            <= '0;
            q_reg.s1         <= '1;
            q_reg.s2         <= '1;
            q_reg.s3         <= '1;
            q_reg.lvl        <= '1;
            q_reg.ctrl       <= mcio_pkg::CTRL_RESET;
            q_reg.st         <= mcio_pkg::ST_IDLE;
            q_reg.doneN      <= 1'b1;
            q_reg.faultSyncN <= 1'b1;
            q_reg.judgeN     <= 6'h3F;
        end else begin
            q_reg <= q_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign bothIn = !q_reg.judgeN[1] && !q_reg.judgeN[4];
    always_comb begin
        case (qty)
            mcio_pkg::QTY_RES:  passN = q_reg.judgeN[1];
            mcio_pkg::QTY_VOLT: passN = q_reg.judgeN[4];
            default:            passN = !bothIn;
        endcase
    end

    assign avs_waitrequest = busSel && !q_reg.ack;
    assign avs_readdata    = q_reg.rdata;
    assign meas_start      = q_reg.measStart;
    assign panel_load      = q_reg.panelLoad;
    assign panel_num       = q_reg.lastPanel;
    assign cal_start       = q_reg.calStart;
    assign zero_start      = q_reg.zeroStart;
    assign print_start     = q_reg.printStart;
    assign accum_start     = q_reg.accumStart;
    assign judge_en        = !cmpMan || !q_reg.lvl[11];
    assign meas_done_n     = q_reg.doneN;
    assign index_n         = (q_reg.st == mcio_pkg::ST_MEAS)
                             || !q_reg.armed;
    assign fault_n         = errSync ? q_reg.faultSyncN
                                     : !probe_fault;
    assign res_above_n     = q_reg.judgeN[2];
    assign res_within_n    = q_reg.judgeN[1];
    assign res_below_n     = q_reg.judgeN[0];
    assign volt_above_n    = q_reg.judgeN[5];
    assign volt_within_n   = q_reg.judgeN[4];
    assign volt_below_n    = q_reg.judgeN[3];
    assign pass_n          = passN;
    assign fail_n          = !passN;
endmodule // mcio_port

// File: tb/mcio_core_model.sv
`timescale 1ns/1ns
module mcio_core_model (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       meas_start,
    input  wire logic [7:0] lat,
    input  wire logic [5:0] judgeSel,
    input  wire logic       faultSel,
    output logic            meas_end,
    output logic            meas_fault,
    output logic [2:0]      res_judge,
    output logic [2:0]      volt_judge
);
    logic [7:0] busyCnt;

    // Bench sets latency: prompt or slow answers
    always_ff @(posedge core_clk) begin
        if (!rst_b || meas_end) begin
            busyCnt <= 8'h00;
        end else if (meas_start) begin
            busyCnt <= 8'h01;
        end else if (busyCnt != 8'h00) begin
            busyCnt <= busyCnt + 8'h01;
        end
    end

    assign meas_end   = (busyCnt != 8'h00) && (busyCnt >= lat);
    assign meas_fault = faultSel;
    assign res_judge  = judgeSel[5:3];
    assign volt_judge = judgeSel[2:0];
endmodule // mcio_core_model

// File: tb/mcio_port_props.sv
`timescale 1ns/1ns
module mcio_port_props #(
    parameter int unsigned SETTLE_CYC = 20
) (
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic        meas_start,
    input wire logic        panel_load,
    input wire logic [6:0]  panel_num,
    input wire logic        cal_start,
    input wire logic        meas_end,
    input wire logic        probe_fault,
    input wire logic        meas_done_n,
    input wire logic        index_n,
    input wire logic        fault_n,
    input wire logic        res_within_n,
    input wire logic        volt_within_n,
    input wire logic        pass_n,
    input wire logic        fail_n
);
    logic [31:0] ctrlReg;
    logic        passExp;
    logic        loadPend;
    int unsigned sinceLoad;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // ****************************************
    // Helpers
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ctrlReg <= mcio_pkg::CTRL_RESET;
        end else if (avs_write && !avs_waitrequest &&
                     avs_address == mcio_pkg::OFS_CTRL) begin
            ctrlReg <= avs_writedata;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_b || meas_start) begin
            loadPend <= 1'b0;
        end else if (panel_load) begin
            loadPend <= 1'b1;
        end
    end
    // Saturates: no wrap in long gaps
    always_ff @(posedge core_clk) begin
        if (panel_load) begin
            sinceLoad <= 1;
        end else if (sinceLoad < SETTLE_CYC + 1) begin
            sinceLoad <= sinceLoad + 1;
        end
    end
    always_comb begin
        case (ctrlReg[6:5])
            2'h1: passExp = res_within_n;
            2'h2: passExp = volt_within_n;
            default: passExp = res_within_n | volt_within_n;
        endcase
    end

    // ****************************************
    // Properties
    // ****************************************
    sequence s_done_low;
        ##[1:3] !meas_done_n;
    endsequence

    a_fail_compl:
        assert property (fail_n != pass_n)
        else $error("fail output equals pass output");
    a_pass_mode:
        assert property (ctrlReg[6:5] != 2'h3 |-> pass_n == passExp)
        else $error("pass output disagrees with mode");
    a_reset_idle:
        assert property ($past(rst_b) == 1'b0 |-> meas_done_n && index_n)
        else $error("done or index active after reset");
    a_int_nomeas:
        assert property (!ctrlReg[0] |-> !meas_start && !panel_load)
        else $error("measurement started in internal mode");
    a_cal_gate:
        assert property (ctrlReg[3:2] == 2'h3 || !ctrlReg[1] |-> !cal_start)
        else $error("calibration started while not allowed");
    a_settle_min:
        assert property (meas_start && loadPend |->
                         sinceLoad >= SETTLE_CYC - 1)
        else $error("measurement before settings settled");
    a_load_valid:
        assert property (panel_load |=>
                         panel_num != 7'h00 && panel_num != 7'h7F)
        else $error("panel load with reserved number");
    a_fault_async:
        assert property (!ctrlReg[7] |-> fault_n == !probe_fault)
        else $error("fault output not following probe");
    a_fault_sync:
        assert property (ctrlReg[7] && $past(ctrlReg[7]) &&
                         $changed(fault_n) |-> $fell(meas_done_n))
        else $error("fault output changed apart from done");
    a_done_after:
        assert property (meas_end |-> s_done_low)
        else $error("done not given after conversion end");
    a_index_meas:
        assert property (meas_end |-> index_n)
        else $error("index active during analog measurement");
    a_start_once:
        assert property (meas_start |=> !meas_start)
        else $error("measurement start longer than one cycle");
endmodule // mcio_port_props

bind mcio_port mcio_port_props #(.SETTLE_CYC(SETTLE_CYC)) u_props (
    .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .meas_start(meas_start),
    .panel_load(panel_load), .panel_num(panel_num), .cal_start(cal_start),
    .meas_end(meas_end), .probe_fault(probe_fault),
    .meas_done_n(meas_done_n), .index_n(index_n), .fault_n(fault_n),
    .res_within_n(res_within_n), .volt_within_n(volt_within_n),
    .pass_n(pass_n), .fail_n(fail_n));

// File: tb/mcio_port_tb_top.sv
`timescale 1ns/1ns
`define CHK(n, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) begin \
            error_cnt++; \
            $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
        end \
    end
module mcio_port_tb_top;
    localparam int SETTLE = 20;
    localparam int CAL = 15;
    localparam int MSC = 4;
    logic        coreClk = 1'b0;
    logic        rstB = 1'b0;
    logic [3:0]  avsAddr = 4'h0;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [31:0] avsWdata = 32'h0000_0000;
    logic [31:0] avsRdata;
    logic        avsWait;
    logic [3:0]  pinN = 4'hF;
    logic [6:0]  panelN = 7'h7F;
    logic        gateN = 1'b1;
    logic        probeFault = 1'b0;
    logic        faultSel = 1'b0;
    logic [5:0]  judgeSel = 6'h12;
    logic [7:0]  lat = 8'h06;
    logic        measEnd, measFault, judgeEn, doneN, indexN, faultN;
    logic        passN, failN;
    logic [2:0]  resJ, voltJ;
    logic [5:0]  ev, cmpN;
    logic [6:0]  panelNum;
    int          cnt [6];
    int          error_cnt = 0;
    int          total_checks = 0;

    // Pins: 3 strobe, 2 self-tune, 1 zero, 0 print
    mcio_port #(.SETTLE_CYC(SETTLE), .CAL_CYC(CAL), .MS_CYC(MSC)) DUT (
        .core_clk(coreClk), .rst_b(rstB), .avs_address(avsAddr),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWdata),
        .avs_byteenable(4'hF), .avs_readdata(avsRdata),
        .avs_waitrequest(avsWait), .trig_n(pinN[3]), .panel_sel_n(panelN),
        .cal_req_n(pinN[2]), .zero_req_n(pinN[1]), .print_req_n(pinN[0]),
        .judge_gate_n(gateN), .meas_end(measEnd), .meas_fault(measFault),
        .probe_fault(probeFault), .res_judge(resJ), .volt_judge(voltJ),
        .meas_start(ev[0]), .panel_load(ev[1]), .panel_num(panelNum),
        .cal_start(ev[3]), .zero_start(ev[4]), .print_start(ev[5]),
        .accum_start(ev[2]), .judge_en(judgeEn), .meas_done_n(doneN),
        .index_n(indexN), .fault_n(faultN), .res_above_n(cmpN[5]),
        .res_within_n(cmpN[4]), .res_below_n(cmpN[3]),
        .volt_above_n(cmpN[2]), .volt_within_n(cmpN[1]),
        .volt_below_n(cmpN[0]), .pass_n(passN), .fail_n(failN));
    mcio_core_model CORE (.core_clk(coreClk), .rst_b(rstB),
        .meas_start(ev[0]), .lat(lat), .judgeSel(judgeSel),
        .faultSel(faultSel), .meas_end(measEnd), .meas_fault(measFault),
        .res_judge(resJ), .volt_judge(voltJ));

    always #20 coreClk = ~coreClk;
    always @(posedge coreClk) begin
        for (int i = 0; i < 6; i++) begin
            if (ev[i] === 1'b1) cnt[i]++;
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge coreClk);
        avsAddr <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWdata <= d;
        do begin
            @(posedge coreClk);
            n++;
        end while (avsWait !== 1'b0 && n < 50);
        q = avsRdata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    // Quiet gap after a settings change
    task automatic setc(input logic [31:0] c);
        logic [31:0] q;
        bus(1'b1, 4'h0, c, q);
        repeat (4) @(posedge coreClk);
    endtask
    task automatic hit(input int p, input int w);
        @(negedge coreClk);
        cnt = '{default: 0};
        @(posedge coreClk);
        pinN[p] <= 1'b0;
        repeat (8) @(posedge coreClk);
        pinN[p] <= 1'b1;
        repeat (w) @(posedge coreClk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        logic [31:0] q;
        `CHK("done_rst", 1'b1, doneN)
        `CHK("index_rst", 1'b1, indexN)
        bus(1'b0, 4'h0, 32'h0000_0000, q);
        `CHK("ctrl_rst", mcio_pkg::CTRL_RESET, q)
        bus(1'b1, 4'h4, 32'hFFFF_FFFF, q);
        bus(1'b0, 4'h4, 32'h0000_0000, q);
        `CHK("unmapped", 32'h0000_0000, q)
        setc(32'h0001_0001);
        bus(1'b0, 4'h0, 32'h0000_0000, q);
        `CHK("ctrl_rw", 32'h0001_0001, q)
        $display("t_regs done");
    endtask
    task automatic t_panel();
        logic [6:0] num [5] = '{7'h05, 7'h05, 7'h7F, 7'h00, 7'h7E};
        int         ld  [5] = '{1, 0, 0, 0, 1};
        for (int i = 0; i < 5; i++) begin
            @(posedge coreClk);
            panelN <= ~num[i];
            lat <= 8'(2 + 3 * i);
            hit(3, 60);
            `CHK("load", ld[i], cnt[1])
            `CHK("meas", 1, cnt[0])
            `CHK("done", 1'b0, doneN)
            `CHK("index", 1'b0, indexN)
            if (ld[i] == 1) `CHK("panel", num[i], panelNum)
        end
        $display("t_panel done");
    endtask
    task automatic t_qty();
        logic [31:0] mode [3] = '{32'h0001_0001, 32'h0001_0021,
                                  32'h0001_0041};
        logic        pas  [3] = '{1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 3; i++) begin
            setc(mode[i]);
            judgeSel <= 6'h14;
            hit(3, 40);
            `CHK("cmp", ~6'h14, cmpN)
            `CHK("pass", pas[i], passN)
            `CHK("fail", ~pas[i], failN)
        end
        $display("t_qty done");
    endtask
    task automatic t_gate();
        setc(32'h0001_0011);
        gateN <= 1'b0;
        judgeSel <= 6'h09;
        hit(3, 40);
        `CHK("gate_on", 1'b1, judgeEn)
        `CHK("latched", ~6'h09, cmpN)
        @(posedge coreClk);
        gateN <= 1'b1;
        judgeSel <= 6'h24;
        hit(3, 40);
        `CHK("gate_off", 1'b0, judgeEn)
        `CHK("held", ~6'h09, cmpN)
        $display("t_gate done");
    endtask
    task automatic t_int();
        setc(32'h0001_0000);
        hit(3, 40);
        `CHK("int_meas", 0, cnt[0])
        `CHK("int_accum", 1, cnt[2])
        $display("t_int done");
    endtask
    task automatic t_cal();
        for (int r = 0; r < 4; r++) begin
            setc({16'h0001, 12'h000, 2'(r), 2'h2});
            hit(2, CAL + 20);
            `CHK("cal", int'(r != 3), cnt[3])
        end
        $display("t_cal done");
    endtask
    task automatic t_zp();
        for (int i = 0; i < 4; i++) begin
            hit(i % 2, 12);
            `CHK("req_once", 1, cnt[5 - i % 2])
            `CHK("req_other", 0, cnt[4 + i % 2])
        end
        $display("t_zp done");
    endtask
    task automatic t_fault();
        setc(32'h0001_0001);
        probeFault <= 1'b1;
        repeat (4) @(posedge coreClk);
        `CHK("async_lo", 1'b0, faultN)
        setc(32'h0001_0081);
        faultSel <= 1'b1;
        hit(3, 40);
        `CHK("sync_lo", 1'b0, faultN)
        faultSel <= 1'b0;
        hit(3, 40);
        `CHK("sync_hi", 1'b1, faultN)
        probeFault <= 1'b0;
        $display("t_fault done");
    endtask
    task automatic t_pulse();
        int n = 0;
        int k = 0;
        setc(32'h0002_0101);
        hit(3, 0);
        while (doneN !== 1'b0 && k < 100) begin
            @(posedge coreClk);
            k++;
        end
        while (doneN === 1'b0 && n < 100) begin
            @(posedge coreClk);
            n++;
        end
        `CHK("eom_width", 2 * MSC, n)
        $display("t_pulse done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge coreClk);
        rstB <= 1'b1;
        @(posedge coreClk);
        t_regs();
        t_panel();
        t_qty();
        t_gate();
        t_int();
        t_cal();
        t_zp();
        t_fault();
        t_pulse();
        end_of_test();
    end
    initial begin
        repeat (6000) @(posedge coreClk);
        error_cnt++;
        end_of_test();
    end
endmodule // mcio_port_tb_top
